/* pkg/token_ctrl_pkg.sv */
package token_ctrl_pkg;

    // ****************************************
    // bus shape and register offsets
    // ****************************************
    localparam int          DATA_W                  = 8;
    localparam int          ADDR_W                  = 4;
    localparam logic [3:0]  ADDR_CONTROL_ZERO       = 4'h0;
    localparam logic [3:0]  ADDR_CONTROL_ONE        = 4'h1;
    localparam logic [3:0]  ADDR_BUFFER_STATUS      = 4'h2;
    localparam logic [3:0]  ADDR_INTERRUPT_EVENTS   = 4'h3;
    localparam logic [3:0]  ADDR_TIMER_RECEIVE      = 4'h4;
    localparam logic [3:0]  ADDR_RING_STATE         = 4'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int          CZ_ISOLATE_REQUEST      = 0;
    localparam int          CZ_MASTER_IRQ_SUPPRESS  = 1;
    localparam int          CZ_COPY_ALL             = 2;
    localparam int          CZ_INTERNAL_LOOPBACK    = 3;
    localparam int          CZ_TOKEN_IRQ_ENABLE     = 4;
    localparam int          CZ_RX_DATA_ENABLE       = 5;
    localparam int          CZ_MASTER_TX_ENABLE     = 6;
    localparam int          CZ_DATA_TX_ENABLE       = 7;
    localparam int          C1_NEXT_ADDR_UPDATE     = 0;
    localparam int          C1_DIAGNOSTIC_SELECT    = 7;
    localparam int          IR_DEAD_OR_MODE_EVENT   = 0;
    localparam int          IR_TOKEN_EVENT          = 2;
    localparam int          RS_STATE_CONFIRM        = 1;
    localparam int          TR_STATUS_LSB           = 5;

    // ****************************************
    // reset values and read masks
    // ****************************************
    localparam logic [7:0]  CONTROL_ZERO_RST        = 8'h01;
    localparam logic [7:0]  CONTROL_ONE_RST         = 8'h00;
    localparam logic [7:0]  CONTROL_ONE_NET_MASK    = 8'hFB;
    localparam logic [7:0]  CONTROL_ONE_DIAG_MASK   = 8'h9F;
    localparam logic [7:0]  BUFFER_STATUS_MASK      = 8'hEF;
    localparam logic [7:0]  TIMER_RECEIVE_ONES      = 8'h1F;
    localparam logic [7:0]  ZERO_BYTE               = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_PERIOD_NS           = 4;
    localparam int          STATE_CHANGE_NS         = 40;
    localparam int          STATE_CHANGE_CYC        =
        (STATE_CHANGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic               sel_n;
        logic               rd_n;
        logic               wr_n;
        logic [3:0]         addr;
        logic [7:0]         wdata;
    } host_req_s;

    typedef struct packed {
        logic [7:0]         buffer_status;
        logic [2:0]         timer_status;
        logic [7:0]         ring_status;
        logic               holds_token;
        logic               tx_frame_busy;
        logic               token_arrived;
        logic [7:0]         event_in;
        logic               next_addr_copied;
    } net_status_s;

    typedef struct packed {
        logic               valid;
        logic               addr_match;
        logic               ack_req;
    } rx_frame_s;

    typedef struct packed {
        logic               data_tx_allow;
        logic               sup_tx_allow;
        logic               rx_data_enable;
        logic               copy_all;
        logic               internal_loopback;
        logic               hold_tx_queue;
        logic               token_pass_req;
        logic               isolated;
        logic               rx_accept;
        logic               rx_nak_not_enabled;
    } net_ctrl_s;

    typedef enum logic [4:0] {
        ST_ISOLATED = 5'b00001,
        ST_JOINING  = 5'b00010,
        ST_NETWORK  = 5'b00100,
        ST_DRAINING = 5'b01000,
        ST_PASSING  = 5'b10000
    } ring_state_e;

endpackage : token_ctrl_pkg

/* core/irq_event_reg.sv */
`timescale 1ns/100ps

module irq_event_reg #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] event_set,
    input  wire logic             read_clear,
    input  wire logic             suppress,
    output logic      [WIDTH-1:0] events_q,
    output logic                  host_irq_n_q
);

    logic [WIDTH-1:0] events_d;
    logic             host_irq_n_d;

    // ****************************************
    // sticky event bits
    // ****************************************
    // a set in the read cycle survives the clear, so no event is lost
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            events_d[i] = event_set[i] | (events_q[i] & ~read_clear);
        end
    end

    always_comb begin
        host_irq_n_d = ~((|events_d) & ~suppress);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            events_q     <= '0;
            host_irq_n_q <= 1'b1;
        end else begin
            events_q     <= events_d;
            host_irq_n_q <= host_irq_n_d;
        end
    end

endmodule : irq_event_reg

/* core/token_ring_host_control_regs.sv */
`timescale 1ns/100ps

module token_ring_host_control_regs #(
    parameter int STATE_CHANGE_CYCLES = token_ctrl_pkg::STATE_CHANGE_CYC
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire token_ctrl_pkg::host_req_s    host_req,
    output logic [token_ctrl_pkg::DATA_W-1:0] host_rdata_q,
    output logic                              host_rdata_oe_q,
    output logic                              host_irq_n,
    input  wire token_ctrl_pkg::net_status_s  net_status,
    input  wire token_ctrl_pkg::rx_frame_s    rx_frame,
    output token_ctrl_pkg::net_ctrl_s         net_ctrl_q
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0]                  control_zero_q;
    logic [7:0]                  control_zero_d;
    logic [7:0]                  control_one_q;
    logic [7:0]                  control_one_d;
    logic                        state_confirm_q;
    logic                        state_confirm_d;
    logic                        rd_seen_q;
    logic                        rd_seen_d;
    logic                        wr_seen_q;
    logic                        wr_seen_d;
    logic [7:0]                  host_rdata_d;
    logic                        host_rdata_oe_d;
    logic [15:0]                 delay_q;
    logic [15:0]                 delay_d;
    token_ctrl_pkg::ring_state_e state_q;
    token_ctrl_pkg::ring_state_e state_d;
    token_ctrl_pkg::net_ctrl_s   net_ctrl_d;
    logic [7:0]                  events_q;
    logic [7:0]                  event_set;
    logic                        iso_event;
    logic                        rd_access;
    logic                        wr_start;
    logic                        rd_start;
    logic                        diag_mode;

    function automatic logic [7:0] read_mux(
        input logic [3:0] addr,
        input logic [7:0] cz,
        input logic [7:0] c1,
        input logic [7:0] ev,
        input logic       confirm,
        input token_ctrl_pkg::net_status_s st
    );
        logic [7:0] v;
        v = token_ctrl_pkg::ZERO_BYTE;
        case (addr)
            token_ctrl_pkg::ADDR_CONTROL_ZERO: begin
                v = cz;
            end
            token_ctrl_pkg::ADDR_CONTROL_ONE: begin
                // reserved bits differ between the two field sets
                if (c1[token_ctrl_pkg::C1_DIAGNOSTIC_SELECT]) begin
                    v = c1 & token_ctrl_pkg::CONTROL_ONE_DIAG_MASK;
                end else begin
                    v = c1 & token_ctrl_pkg::CONTROL_ONE_NET_MASK;
                end
            end
            token_ctrl_pkg::ADDR_BUFFER_STATUS: begin
                v = st.buffer_status & token_ctrl_pkg::BUFFER_STATUS_MASK;
            end
            token_ctrl_pkg::ADDR_INTERRUPT_EVENTS: begin
                v = ev;
            end
            token_ctrl_pkg::ADDR_TIMER_RECEIVE: begin
                v = token_ctrl_pkg::TIMER_RECEIVE_ONES;
                v[7:token_ctrl_pkg::TR_STATUS_LSB] = st.timer_status;
            end
            token_ctrl_pkg::ADDR_RING_STATE: begin
                v = st.ring_status;
                v[token_ctrl_pkg::RS_STATE_CONFIRM] = confirm;
            end
            default: begin
                v = token_ctrl_pkg::ZERO_BYTE;
            end
        endcase
        return v;
    endfunction : read_mux

    // ****************************************
    // host register port
    // ****************************************
    always_comb begin
        rd_access = ~host_req.sel_n & ~host_req.rd_n;
        rd_start  = rd_access & ~rd_seen_q;
        wr_start  = ~host_req.sel_n & ~host_req.wr_n & ~wr_seen_q;
        rd_seen_d = rd_access;
        wr_seen_d = ~host_req.sel_n & ~host_req.wr_n;
        diag_mode = control_one_q[token_ctrl_pkg::C1_DIAGNOSTIC_SELECT];

        host_rdata_oe_d = rd_access;
        host_rdata_d    = host_rdata_q;
        if (rd_start) begin
            host_rdata_d = read_mux(host_req.addr, control_zero_q, control_one_q,
                                    events_q, state_confirm_q, net_status);
        end

        control_zero_d = control_zero_q;
        control_one_d  = control_one_q;
        if (net_status.next_addr_copied) begin
            control_one_d[token_ctrl_pkg::C1_NEXT_ADDR_UPDATE] = 1'b0;
        end
        // only the two control registers take writes; the rest drop them
        if (wr_start) begin
            case (host_req.addr)
                token_ctrl_pkg::ADDR_CONTROL_ZERO: begin
                    control_zero_d = host_req.wdata;
                end
                token_ctrl_pkg::ADDR_CONTROL_ONE: begin
                    control_one_d = host_req.wdata;
                end
                default: begin
                    control_zero_d = control_zero_q;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_zero_q  <= token_ctrl_pkg::CONTROL_ZERO_RST;
            control_one_q   <= token_ctrl_pkg::CONTROL_ONE_RST;
            rd_seen_q       <= 1'b0;
            wr_seen_q       <= 1'b0;
            host_rdata_q    <= token_ctrl_pkg::ZERO_BYTE;
            host_rdata_oe_q <= 1'b0;
        end else begin
            control_zero_q  <= control_zero_d;
            control_one_q   <= control_one_d;
            rd_seen_q       <= rd_seen_d;
            wr_seen_q       <= wr_seen_d;
            host_rdata_q    <= host_rdata_d;
            host_rdata_oe_q <= host_rdata_oe_d;
        end
    end

    // ****************************************
    // isolate / network state machine
    // ****************************************
    // the host must poll the confirm bit; the join takes a fixed delay
    always_comb begin
        state_d         = state_q;
        delay_d         = delay_q;
        state_confirm_d = state_confirm_q;
        iso_event       = 1'b0;
        case (state_q)
            token_ctrl_pkg::ST_ISOLATED: begin
                // a diagnostic session freezes the isolate bit's effect
                if (!control_zero_q[token_ctrl_pkg::CZ_ISOLATE_REQUEST] && !diag_mode) begin
                    state_d = token_ctrl_pkg::ST_JOINING;
                    delay_d = 16'(STATE_CHANGE_CYCLES);
                end
            end
            token_ctrl_pkg::ST_JOINING: begin
                if (control_zero_q[token_ctrl_pkg::CZ_ISOLATE_REQUEST]) begin
                    state_d = token_ctrl_pkg::ST_ISOLATED;
                end else if (delay_q <= 16'h0001) begin
                    state_d         = token_ctrl_pkg::ST_NETWORK;
                    state_confirm_d = 1'b0;
                end else begin
                    delay_d = delay_q - 16'h0001;
                end
            end
            token_ctrl_pkg::ST_NETWORK: begin
                if (control_zero_q[token_ctrl_pkg::CZ_ISOLATE_REQUEST] && !diag_mode) begin
                    state_d = token_ctrl_pkg::ST_DRAINING;
                end
            end
            token_ctrl_pkg::ST_DRAINING: begin
                // the frame on the wire completes; queued ones wait
                if (!net_status.tx_frame_busy) begin
                    if (net_status.holds_token) begin
                        state_d = token_ctrl_pkg::ST_PASSING;
                    end else begin
                        state_d         = token_ctrl_pkg::ST_ISOLATED;
                        state_confirm_d = 1'b1;
                        iso_event       = 1'b1;
                    end
                end
            end
            token_ctrl_pkg::ST_PASSING: begin
                if (!net_status.holds_token) begin
                    state_d         = token_ctrl_pkg::ST_ISOLATED;
                    state_confirm_d = 1'b1;
                    iso_event       = 1'b1;
                end
            end
            default: begin
                state_d = token_ctrl_pkg::ST_ISOLATED;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= token_ctrl_pkg::ST_ISOLATED;
            delay_q         <= 16'h0000;
            state_confirm_q <= 1'b1;
        end else begin
            state_q         <= state_d;
            delay_q         <= delay_d;
            state_confirm_q <= state_confirm_d;
        end
    end

    // ****************************************
    // interrupt events
    // ****************************************
    always_comb begin
        event_set = net_status.event_in;
        event_set[token_ctrl_pkg::IR_DEAD_OR_MODE_EVENT] =
            net_status.event_in[token_ctrl_pkg::IR_DEAD_OR_MODE_EVENT] | iso_event;
        event_set[token_ctrl_pkg::IR_TOKEN_EVENT] = net_status.token_arrived
            & control_zero_q[token_ctrl_pkg::CZ_TOKEN_IRQ_ENABLE];
    end

    irq_event_reg #(
        .WIDTH        (token_ctrl_pkg::DATA_W)
    ) u_irq_event_reg (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .event_set    (event_set),
        .read_clear   (rd_start && host_req.addr == token_ctrl_pkg::ADDR_INTERRUPT_EVENTS),
        .suppress     (control_zero_q[token_ctrl_pkg::CZ_MASTER_IRQ_SUPPRESS]),
        .events_q     (events_q),
        .host_irq_n_q (host_irq_n)
    );

    // ****************************************
    // controls toward the protocol engine
    // ****************************************
    always_comb begin
        net_ctrl_d = '0;
        net_ctrl_d.isolated          = state_q == token_ctrl_pkg::ST_ISOLATED;
        net_ctrl_d.sup_tx_allow      = control_zero_q[token_ctrl_pkg::CZ_MASTER_TX_ENABLE];
        net_ctrl_d.data_tx_allow     = control_zero_q[token_ctrl_pkg::CZ_MASTER_TX_ENABLE]
            & control_zero_q[token_ctrl_pkg::CZ_DATA_TX_ENABLE]
            & (state_q == token_ctrl_pkg::ST_NETWORK);
        net_ctrl_d.hold_tx_queue     = state_q == token_ctrl_pkg::ST_DRAINING
            || state_q == token_ctrl_pkg::ST_PASSING;
        net_ctrl_d.token_pass_req    = state_q == token_ctrl_pkg::ST_DRAINING
            && state_d == token_ctrl_pkg::ST_PASSING;
        net_ctrl_d.rx_data_enable    = control_zero_q[token_ctrl_pkg::CZ_RX_DATA_ENABLE];
        net_ctrl_d.copy_all          = control_zero_q[token_ctrl_pkg::CZ_COPY_ALL];
        // relies on the host keeping loopback off while in network
        net_ctrl_d.internal_loopback = control_zero_q[token_ctrl_pkg::CZ_INTERNAL_LOOPBACK];
        net_ctrl_d.rx_accept         = rx_frame.valid
            & control_zero_q[token_ctrl_pkg::CZ_RX_DATA_ENABLE]
            & (rx_frame.addr_match | control_zero_q[token_ctrl_pkg::CZ_COPY_ALL]);
        net_ctrl_d.rx_nak_not_enabled = rx_frame.valid & rx_frame.addr_match & rx_frame.ack_req
            & ~control_zero_q[token_ctrl_pkg::CZ_RX_DATA_ENABLE];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            net_ctrl_q <= '0;
        end else begin
            net_ctrl_q <= net_ctrl_d;
        end
    end

endmodule : token_ring_host_control_regs

/* dv/token_regs_chk.sv */
`timescale 1ns/100ps

module token_regs_chk #(
    parameter int STATE_CHANGE_CYCLES = 10
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    input  wire token_ctrl_pkg::host_req_s    host_req,
    input  wire logic [token_ctrl_pkg::DATA_W-1:0] host_rdata_q,
    input  wire logic                         host_rdata_oe_q,
    input  wire logic                         host_irq_n,
    input  wire token_ctrl_pkg::net_status_s  net_status,
    input  wire token_ctrl_pkg::rx_frame_s    rx_frame,
    input  wire token_ctrl_pkg::net_ctrl_s    net_ctrl_q
);
    // ****************************************
    // shadow of control_zero, seen only through bus writes
    // ****************************************
    logic       rd_q;
    logic       wr_q;
    logic [7:0] cz_q;
    wire        rd_go = !host_req.sel_n && !host_req.rd_n && !rd_q;
    wire        wr_go = !host_req.sel_n && !host_req.wr_n && !wr_q;
    wire        sup   = cz_q[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'h0;
            wr_q <= 1'h0;
            cz_q <= token_ctrl_pkg::CONTROL_ZERO_RST;
        end else begin
            rd_q <= !host_req.sel_n && !host_req.rd_n;
            wr_q <= !host_req.sel_n && !host_req.wr_n;
            if (wr_go && host_req.addr == token_ctrl_pkg::ADDR_CONTROL_ZERO) begin
                cz_q <= host_req.wdata;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_RESET_ISOLATED: assert property ($rose(rst_n) |=> net_ctrl_q.isolated)
        else $error("not isolated after reset");
    AST_IRQ_RAISE: assert property ((!sup && |(net_status.event_in & 8'hFB)) ##1
        (!rd_go && !sup) |=> !host_irq_n) else $error("interrupt not raised");
    AST_IRQ_CLEAR: assert property ((rd_go && host_req.addr == 4'h3
        && net_status.event_in == 8'h00 && !net_status.token_arrived)
        ##1 !net_ctrl_q.hold_tx_queue |-> host_irq_n)
        else $error("interrupt kept after event read");
    AST_IRQ_SUPPRESS: assert property (sup && $past(sup) |-> host_irq_n)
        else $error("interrupt while suppressed");
    AST_TOKEN_EVENT: assert property ((net_status.token_arrived && cz_q[4] && !sup)
        ##1 (!rd_go && !sup) |=> !host_irq_n) else $error("token event lost");
    AST_LEAVE_EVENT: assert property ($fell(net_ctrl_q.hold_tx_queue) && !sup
        |-> ##[0:3] !host_irq_n) else $error("no event on isolate");
    AST_POSTPONE: assert property ($rose(net_ctrl_q.isolated) |->
        !$past(net_status.holds_token) && !$past(net_status.tx_frame_busy))
        else $error("isolated while token held");
    AST_DATA_GATE: assert property (net_ctrl_q.data_tx_allow |->
        net_ctrl_q.sup_tx_allow && !net_ctrl_q.isolated) else $error("data tx leak");
    AST_RX_NAK: assert property (rx_frame.valid && rx_frame.addr_match
        && rx_frame.ack_req && !cz_q[5] && !net_ctrl_q.isolated
        |=> net_ctrl_q.rx_nak_not_enabled && !net_ctrl_q.rx_accept) else $error("no nak");
    AST_COPY_ALL: assert property (rx_frame.valid && !rx_frame.addr_match
        && cz_q[2] && cz_q[5] && !net_ctrl_q.isolated
        |=> net_ctrl_q.rx_accept) else $error("copy mode dropped frame");
    AST_OE_DRIVE: assert property (rd_go |=> host_rdata_oe_q)
        else $error("read data not driven");
endmodule : token_regs_chk

bind token_ring_host_control_regs token_regs_chk #(
    .STATE_CHANGE_CYCLES(STATE_CHANGE_CYCLES)
) i_token_regs_chk (.ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req),
    .host_rdata_q(host_rdata_q), .host_rdata_oe_q(host_rdata_oe_q),
    .host_irq_n(host_irq_n), .net_status(net_status), .rx_frame(rx_frame),
    .net_ctrl_q(net_ctrl_q));

/* dv/host_cpu_model.sv */
`timescale 1ns/100ps

module host_cpu_model (
    input  wire logic                    ref_clk,
    input  wire logic [7:0]              rdata,
    output token_ctrl_pkg::host_req_s    req
);
    initial req = '{1'h1, 1'h1, 1'h1, 4'h0, 8'h00};

    // strobe held over two edges, then one idle cycle for the edge detect
    task automatic access(input logic rd, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge ref_clk);
        req = '{1'h0, !rd, rd, a, d};
        repeat (2) @(negedge ref_clk);
        q = rdata;
        req = '{1'h1, 1'h1, 1'h1, a, d};
        @(negedge ref_clk);
    endtask : access
endmodule : host_cpu_model

/* dv/test_token_ring_host_control_regs.sv */
`timescale 1ns/100ps

module test_token_ring_host_control_regs;
    localparam int SCC = 2;
    logic                        ref_clk;
    logic                        rst_n;
    token_ctrl_pkg::host_req_s   req;
    logic [7:0]                  rdata;
    logic [7:0]                  q;
    logic [7:0]                  v;
    logic                        oe;
    logic                        irq_n;
    token_ctrl_pkg::net_status_s ns;
    token_ctrl_pkg::rx_frame_s   rx;
    token_ctrl_pkg::net_ctrl_s   nc;
    int                          fail_count;
    int                          comparisons;
    int                          seed;

    token_ring_host_control_regs #(.STATE_CHANGE_CYCLES(SCC)) i_token_ring_host_control_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .host_req(req), .host_rdata_q(rdata),
        .host_rdata_oe_q(oe), .host_irq_n(irq_n), .net_status(ns), .rx_frame(rx),
        .net_ctrl_q(nc));
    host_cpu_model i_host_cpu_model (.ref_clk(ref_clk), .rdata(rdata), .req(req));

    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = !ref_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [3:0] a);
        i_host_cpu_model.access(1'h1, a, 8'h00, q);
    endtask : rd
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_host_cpu_model.access(1'h0, a, d, q);
    endtask : wr
    task automatic pulse(input logic [7:0] e, input logic t);
        @(negedge ref_clk);
        ns.event_in = e;
        ns.token_arrived = t;
        @(negedge ref_clk);
        ns.event_in = 8'h00;
        ns.token_arrived = 1'h0;
        @(negedge ref_clk);
    endtask : pulse
    task automatic frame(input logic m, input logic k);
        @(negedge ref_clk);
        rx = '{1'h1, m, k};
        @(negedge ref_clk);
        rx = '0;
        v = {6'h0, nc.rx_accept, nc.rx_nak_not_enabled};
    endtask : frame
    // host waits for the confirmation instead of assuming the change
    task automatic wait_state(input logic want);
        for (int k = 0; k < 40 && (k == 0 || q[1] !== want); k++) begin
            rd(token_ctrl_pkg::ADDR_RING_STATE);
        end
        chk({7'h0, q[1]}, {7'h0, want}, "state confirm");
    endtask : wait_state
    function automatic logic [7:0] exp_c1(input logic [7:0] d);
        return d & (d[7] ? token_ctrl_pkg::CONTROL_ONE_DIAG_MASK
                         : token_ctrl_pkg::CONTROL_ONE_NET_MASK);
    endfunction : exp_c1
    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("mismatch t=%0t watchdog expired", $time);
        final_report;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        seed = 76935;
        fail_count = 0;
        comparisons = 0;
        rst_n = 1'h0;
        ns = '0;
        rx = '0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'h1;
        ns.buffer_status = 8'($random(seed));
        ns.timer_status = 3'($random(seed));
        rd(token_ctrl_pkg::ADDR_CONTROL_ZERO);
        chk(q, token_ctrl_pkg::CONTROL_ZERO_RST, "reset isolate");
        wr(token_ctrl_pkg::ADDR_BUFFER_STATUS, 8'hFF);
        rd(token_ctrl_pkg::ADDR_BUFFER_STATUS);
        chk(q, ns.buffer_status & token_ctrl_pkg::BUFFER_STATUS_MASK, "buffer");
        wr(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS, 8'hFF);
        rd(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS);
        chk(q, 8'h00, "events written");
        rd(token_ctrl_pkg::ADDR_TIMER_RECEIVE);
        chk(q, {ns.timer_status, 5'h1F}, "timer");
        $display("test reset done");
        // loopback only while isolated, the host side keeps that
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed)) | 8'h01;
            wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, v);
            rd(token_ctrl_pkg::ADDR_CONTROL_ZERO);
            chk(q, v, "control_zero");
            chk({3'h0, nc.copy_all, nc.internal_loopback, nc.rx_data_enable, nc.sup_tx_allow,
            nc.data_tx_allow}, {3'h0, v[2], v[3], v[5], v[6], 1'h0}, "ctrl");
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h7E : 8'($random(seed));
            wr(token_ctrl_pkg::ADDR_CONTROL_ONE, v);
            rd(token_ctrl_pkg::ADDR_CONTROL_ONE);
            chk(q, exp_c1(v), "control_one");
        end
        wr(token_ctrl_pkg::ADDR_CONTROL_ONE, 8'h80);
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'h00);
        repeat (SCC + 6) @(negedge ref_clk);
        chk({7'h0, nc.isolated}, 8'h01, "diag ignores isolate");
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'h01);
        wr(token_ctrl_pkg::ADDR_CONTROL_ONE, 8'h00);
        $display("test registers done");
        // master tx on and isolate off in one write, then wait for the confirm
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'h40);
        wait_state(1'h0);
        chk({6'h0, nc.sup_tx_allow, nc.data_tx_allow}, 8'h02, "data tx off");
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'h00);
        chk({6'h0, nc.sup_tx_allow, nc.data_tx_allow}, 8'h00, "tx off");
        frame(1'h1, 1'h1);
        chk(v, 8'h01, "nak");
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'hE4);
        chk({7'h0, nc.data_tx_allow}, 8'h01, "data tx on");
        frame(1'h0, 1'h0);
        chk(v, 8'h02, "copy");
        $display("test network done");
        pulse(8'h08, 1'h0);
        chk({7'h0, irq_n}, 8'h00, "irq low");
        rd(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS);
        chk(q, 8'h08, "events");
        chk({6'h0, oe, irq_n}, 8'h01, "irq cleared");
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'hE6);
        pulse(8'h08, 1'h0);
        chk({7'h0, irq_n}, 8'h01, "irq suppressed");
        rd(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS);
        chk(q, 8'h08, "events suppressed");
        for (int e = 0; e < 2; e++) begin
            wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, e ? 8'hE4 : 8'hF4);
            pulse(8'h00, 1'h1);
            rd(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS);
            chk(q, e ? 8'h00 : 8'h04, "token event");
        end
        $display("test interrupt done");
        ns.holds_token = 1'h1;
        ns.tx_frame_busy = 1'h1;
        wr(token_ctrl_pkg::ADDR_CONTROL_ZERO, 8'hE5);
        repeat (12) @(negedge ref_clk);
        chk({6'h0, nc.isolated, nc.hold_tx_queue}, 8'h01, "postponed");
        ns.tx_frame_busy = 1'h0;
        for (int k = 0; k < 30 && nc.token_pass_req !== 1'h1; k++) begin
            @(negedge ref_clk);
        end
        chk({7'h0, nc.token_pass_req}, 8'h01, "token pass");
        ns.holds_token = 1'h0;
        wait_state(1'h1);
        chk({6'h0, nc.isolated, irq_n}, 8'h02, "isolated irq");
        rd(token_ctrl_pkg::ADDR_INTERRUPT_EVENTS);
        chk(q, 8'h01, "isolate event");
        $display("test isolate done");
        final_report;
    end
endmodule : test_token_ring_host_control_regs
